/* rtl/ctw_pkg.sv */
// Shared constants and types for the core timer and watchdog block.
// Assumes one instruction clock of CTW_MCLK_HZ drives all users of this package.
package ctw_pkg;

  localparam int CTW_CNT_W = 8;
  localparam int CTW_OSC_W = 12;
  localparam logic [CTW_CNT_W-1:0] CTW_CNT_MAX = 8'hff;
  localparam logic [CTW_CNT_W-1:0] CTW_CNT_ZERO = 8'h00;
  localparam logic [CTW_CNT_W-1:0] CTW_CNT_ONE = 8'h01;
  localparam logic [CTW_OSC_W-1:0] CTW_OSC_ZERO = 12'h000;
  localparam logic [CTW_OSC_W-1:0] CTW_OSC_ONE = 12'h001;

  // Timing of the watchdog oscillator, modelled as a tick derived from the instruction clock.
  localparam int CTW_MCLK_HZ = 40_000_000;
  localparam int CTW_WDT_OSC_HZ = 14_000;
  localparam int CTW_WDT_TICK_CYC = CTW_MCLK_HZ / CTW_WDT_OSC_HZ;
  localparam logic [CTW_OSC_W-1:0] CTW_WDT_TICK_LAST = CTW_OSC_W'(CTW_WDT_TICK_CYC - 1);

  // Pending flag position inside the timer-1 control B image.
  localparam int CTW_T1CB_PEND_BIT = 7;

  // Config_word_a and flag levels.
  localparam logic CTW_CONFIG_WORD_A_PROGRAMMED = 1'b0;
  localparam logic CTW_WDT_CONFIG_WORD_A_ON = 1'b1;
  localparam logic CTW_TO_RST = 1'b1;
  localparam logic CTW_PD_RST = 1'b1;
  localparam logic CTW_SRC_PIN = 1'b1;
  localparam logic CTW_EDGE_FALL = 1'b1;
  localparam logic CTW_SCL_TO_WDT = 1'b1;

  typedef struct packed {
    logic count_src_select;
    logic count_edge_select;
    logic scaler_assign;
    logic [2:0] scale_select;
    logic rollover_irq_disable;
    logic counter_map_select;
  } ctw_option_t;

  typedef enum logic [1:0] {
    CTW_RUN = 2'b01,
    CTW_SLEEP = 2'b10
  } ctw_power_t;

endpackage

/* rtl/ctw_pin_edge.sv */
// Synchroniser and edge detector for the counter input pin.
// Assumes the pin is asynchronous to mclk; emits at most one pulse per clock.
`timescale 1ns/1ps
module ctw_pin_edge
  import ctw_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Pin and polarity.
  input wire logic counter_pin,
  input wire logic count_edge_select,
  // Event.
  output logic edge_pulse
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic edge_ff;
  logic rise;
  logic fall;
  logic nxt_edge;

  assign rise = sync2_ff & ~prev_ff;
  assign fall = prev_ff & ~sync2_ff;
  assign nxt_edge = (count_edge_select == CTW_EDGE_FALL) ? fall : rise; // R21
  assign edge_pulse = edge_ff;

  // Several pin edges inside one clock collapse into at most one sampled change.
  always_ff @(posedge mclk or posedge sys_rst) begin // R2
    if (sys_rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
      edge_ff <= 1'b0;
    end else begin
      sync1_ff <= counter_pin;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      edge_ff <= nxt_edge;
    end
  end

endmodule // ctw_pin_edge

/* rtl/ctw_core_timer_watchdog.sv */
// Real-time counter, shared scaler and watchdog of the core timing unit.
// Assumes instruction strobes and option bits come from core logic on mclk; only the counter pin is asynchronous.
`timescale 1ns/1ps

// What this block does
// R1 - Pin edges advance counter in pin mode.
// R2 - At most one pin event per cycle.
// R3 - Scaler divides source before counter advances.
// R4 - Counter wrap raises interrupt when enabled.
// R5 - Interrupt and map bits need programmed config_word_a.
// R6 - Interrupt control bit is active low.
// R7 - Large variant sets pending bit seven.
// R8 - Config_word_a enables watchdog, enabled by default.
// R9 - Watchdog counts from its own oscillator.
// R10 - Watchdog timeout resets device, clears timeout.
// R11 - Service clears watchdog and scaler.
// R12 - Service sets timeout and powerdown flags.
// R13 - Powerdown instruction clears powerdown flag.
// R14 - Watchdog count is not externally accessible.
// R15 - Software services within eighteen milliseconds.
// R16 - Scaler serves watchdog or counter, not both.
// R17 - Watchdog scaler extends timeout by powers two.
// R18 - Watchdog runs in powerdown and wakes.
// R19 - Disabled watchdog stops oscillator and counter.
// R20 - Source bit selects pin or cycles.
// R21 - Edge bit selects rising or falling.
module ctw_core_timer_watchdog
  import ctw_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Config_word_a word.
  input wire logic watchdog_enable_config_word_a,
  input wire logic ext_option_config_word_a,
  // Option bits.
  input wire ctw_option_t option,
  // Counter input pin, asynchronous.
  input wire logic counter_pin,
  // Core strobes, one cycle each.
  input wire logic watchdog_service_instruction,
  input wire logic powerdown_instruction,
  input wire logic counter_wr,
  input wire logic [CTW_CNT_W-1:0] counter_wr_data,
  input wire logic pending_clr,
  // Real-time counter results.
  output logic [CTW_CNT_W-1:0] realtime_counter,
  output logic rollover_irq,
  output logic [CTW_CNT_W-1:0] timer1_control_b,
  output logic counter_map_effective,
  // Watchdog and power results.
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic watchdog_reset,
  output logic watchdog_wake,
  output logic asleep
);

  // Carry out of scaler bit sel when the scaler steps: divide by two to the sel plus one.
  function automatic logic scl_carry(input logic [CTW_CNT_W-1:0] v, input logic [2:0] sel);
    logic c;
    c = 1'b1;
    for (int i = 0; i < CTW_CNT_W; i++) begin
      if (i <= int'(sel)) begin
        c = c & v[i];
      end
    end
    return c;
  endfunction

  // Number of watchdog wraps per timeout.
  function automatic logic [CTW_CNT_W:0] wdt_factor(input logic [2:0] sel);
    return (CTW_CNT_W+1)'(1) << sel;
  endfunction

  logic [CTW_CNT_W-1:0] rtc_ff;
  logic [CTW_CNT_W-1:0] nxt_rtc;
  logic [CTW_CNT_W-1:0] scl_ff;
  logic [CTW_CNT_W-1:0] nxt_scl;
  logic [CTW_CNT_W-1:0] wdt_ff;
  logic [CTW_CNT_W-1:0] nxt_wdt;
  logic [CTW_OSC_W-1:0] osc_ff;
  logic [CTW_OSC_W-1:0] nxt_osc;
  logic [CTW_CNT_W-1:0] t1cb_ff;
  logic irq_ff;
  logic map_ff;
  logic to_ff;
  logic pd_ff;
  logic rst_ff;
  logic wake_ff;
  logic asleep_ff;
  ctw_power_t pwr_ff;
  ctw_power_t nxt_pwr;

  logic pin_edge;
  logic running;
  logic wdt_on;
  logic config_word_a_open;
  logic irq_en;
  logic src_event;
  logic rtc_pre;
  logic scl_inc_rtc;
  logic rtc_step;
  logic rtc_wrap;
  logic wdt_tick;
  logic wdt_wrap;
  logic wdt_post;
  logic [CTW_CNT_W:0] wrap_count;
  logic timeout;
  logic nxt_to;
  logic nxt_pd;
  logic nxt_pend;

  ctw_pin_edge u_pin_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .counter_pin(counter_pin),
    .count_edge_select(option.count_edge_select),
    .edge_pulse(pin_edge)
  );

  // Real-time counter side. The device clock stops in powerdown, so the counter holds there.
  assign running = (pwr_ff == CTW_RUN);
  assign config_word_a_open = (ext_option_config_word_a == CTW_CONFIG_WORD_A_PROGRAMMED); // R5
  assign irq_en = config_word_a_open & ~option.rollover_irq_disable; // R6
  assign src_event = (option.count_src_select == CTW_SRC_PIN) ? pin_edge : 1'b1; // R20 R1
  assign rtc_pre = (option.scaler_assign != CTW_SCL_TO_WDT); // R16
  assign scl_inc_rtc = rtc_pre & src_event & running;
  assign rtc_step = rtc_pre ? (scl_inc_rtc & scl_carry(scl_ff, option.scale_select)) // R3
                            : (src_event & running); // R1
  assign rtc_wrap = rtc_step & ~counter_wr & (rtc_ff == CTW_CNT_MAX); // R4
  assign nxt_rtc = counter_wr ? counter_wr_data
                 : (rtc_step ? CTW_CNT_W'(rtc_ff + CTW_CNT_ONE) : rtc_ff);
  assign nxt_pend = LARGE_VARIANT & (rtc_wrap | (t1cb_ff[CTW_T1CB_PEND_BIT] & ~pending_clr)); // R7

  // Watchdog side. The tick divider stands in for the separate low-rate oscillator.
  assign wdt_on = (watchdog_enable_config_word_a == CTW_WDT_CONFIG_WORD_A_ON); // R8
  assign wdt_tick = wdt_on & (osc_ff == CTW_WDT_TICK_LAST); // R9
  assign nxt_osc = ~wdt_on ? osc_ff // R19
                 : (wdt_tick ? CTW_OSC_ZERO : CTW_OSC_W'(osc_ff + CTW_OSC_ONE));
  assign wdt_wrap = wdt_tick & (wdt_ff == CTW_CNT_MAX);
  assign wdt_post = ~rtc_pre; // R16
  assign wrap_count = (CTW_CNT_W+1)'(scl_ff) + (CTW_CNT_W+1)'(1);
  // A scale change mid-run may leave the wrap count above the new factor, so compare with at least.
  assign timeout = wdt_wrap & (~wdt_post | (wrap_count >= wdt_factor(option.scale_select))); // R10 R17
  // The watchdog count has no read or write path; only service and ticks touch it.
  assign nxt_wdt = watchdog_service_instruction ? CTW_CNT_ZERO // R11 R14
                 : (wdt_tick ? CTW_CNT_W'(wdt_ff + CTW_CNT_ONE) : wdt_ff); // R19
  assign nxt_scl = (watchdog_service_instruction | timeout) ? CTW_CNT_ZERO // R11
                 : ((wdt_post & wdt_wrap) | scl_inc_rtc) ? CTW_CNT_W'(scl_ff + CTW_CNT_ONE) : scl_ff;
  // A timeout in the same cycle as a service still clears the flag, so the event is kept.
  assign nxt_to = timeout ? 1'b0 : (watchdog_service_instruction ? 1'b1 : to_ff); // R10 R12
  assign nxt_pd = watchdog_service_instruction ? 1'b1 : (powerdown_instruction ? 1'b0 : pd_ff); // R12 R13

  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      CTW_RUN: begin
        if (powerdown_instruction && !timeout) begin
          nxt_pwr = CTW_SLEEP;
        end
      end
      CTW_SLEEP: begin
        if (timeout) begin // R18
          nxt_pwr = CTW_RUN;
        end
      end
      default: begin
        nxt_pwr = CTW_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_ff <= CTW_CNT_ZERO;
      scl_ff <= CTW_CNT_ZERO;
      t1cb_ff <= CTW_CNT_ZERO;
      irq_ff <= 1'b0;
      map_ff <= 1'b0;
    end else begin
      rtc_ff <= nxt_rtc;
      scl_ff <= nxt_scl;
      t1cb_ff[CTW_T1CB_PEND_BIT] <= nxt_pend; // R7
      irq_ff <= rtc_wrap & irq_en; // R4
      map_ff <= config_word_a_open & option.counter_map_select; // R5
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_ff <= CTW_CNT_ZERO;
      osc_ff <= CTW_OSC_ZERO;
      to_ff <= CTW_TO_RST;
      pd_ff <= CTW_PD_RST;
      rst_ff <= 1'b0;
      wake_ff <= 1'b0;
      asleep_ff <= 1'b0;
      pwr_ff <= CTW_RUN;
    end else begin
      wdt_ff <= nxt_wdt;
      osc_ff <= nxt_osc;
      to_ff <= nxt_to;
      pd_ff <= nxt_pd;
      rst_ff <= timeout; // R10
      wake_ff <= timeout & (pwr_ff == CTW_SLEEP); // R18
      asleep_ff <= (nxt_pwr == CTW_SLEEP);
      pwr_ff <= nxt_pwr;
    end
  end

  assign realtime_counter = rtc_ff;
  assign rollover_irq = irq_ff;
  assign timer1_control_b = t1cb_ff;
  assign counter_map_effective = map_ff;
  assign timeout_flag = to_ff;
  assign powerdown_flag = pd_ff;
  assign watchdog_reset = rst_ff;
  assign watchdog_wake = wake_ff;
  assign asleep = asleep_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_pin_count: assert property ( // R1
    option.count_src_select && !rtc_pre && running && !counter_wr && pin_edge
    |=> rtc_ff == CTW_CNT_W'($past(rtc_ff) + CTW_CNT_ONE))
    else $error("pin edge did not advance the counter");

  chk_cycle_count: assert property ( // R20
    !option.count_src_select && !rtc_pre && running && !counter_wr
    |=> rtc_ff == CTW_CNT_W'($past(rtc_ff) + CTW_CNT_ONE))
    else $error("cycle mode did not advance the counter");

  chk_prescale_hold: assert property ( // R3
    rtc_pre && !counter_wr && !scl_carry(scl_ff, option.scale_select) |=> $stable(rtc_ff))
    else $error("counter moved without a scaler carry");

  chk_irq_raise: assert property ( // R4
    rtc_wrap && !option.rollover_irq_disable && !ext_option_config_word_a |=> rollover_irq && rtc_ff == CTW_CNT_ZERO)
    else $error("rollover did not raise the interrupt");

  chk_irq_config_word_a: assert property ( // R5
    ext_option_config_word_a || option.rollover_irq_disable |=> !rollover_irq)
    else $error("interrupt raised while gated off");

  chk_pend_flag: assert property ( // R7
    rtc_wrap |=> timer1_control_b[CTW_T1CB_PEND_BIT] == LARGE_VARIANT)
    else $error("pending flag wrong after rollover");

  chk_wdt_tick: assert property ( // R9
    wdt_tick && !watchdog_service_instruction |=> wdt_ff == CTW_CNT_W'($past(wdt_ff) + CTW_CNT_ONE))
    else $error("watchdog tick lost");

  chk_timeout_out: assert property ( // R10
    timeout |=> watchdog_reset && !timeout_flag ##1 !watchdog_reset)
    else $error("timeout did not reset and clear flag");

  chk_service_clr: assert property ( // R11
    watchdog_service_instruction |=> wdt_ff == CTW_CNT_ZERO && scl_ff == CTW_CNT_ZERO)
    else $error("service left watchdog or scaler nonzero");

  chk_service_flags: assert property ( // R12
    watchdog_service_instruction && !timeout |=> timeout_flag && powerdown_flag)
    else $error("service did not set both flags");

  chk_sleep_flag: assert property ( // R13
    powerdown_instruction && !watchdog_service_instruction |=> !powerdown_flag)
    else $error("powerdown flag not cleared");

  chk_scaler_owner: assert property ( // R16
    wdt_post && !wdt_wrap && !watchdog_service_instruction |=> $stable(scl_ff))
    else $error("watchdog scaler moved without a wrap");

  chk_wake_up: assert property ( // R18
    timeout && pwr_ff == CTW_SLEEP |=> watchdog_wake && !asleep)
    else $error("watchdog timeout did not wake");

  chk_wdt_stop: assert property ( // R19
    !watchdog_enable_config_word_a && !watchdog_service_instruction |=> $stable(wdt_ff) && $stable(osc_ff))
    else $error("disabled watchdog kept running");

endmodule // ctw_core_timer_watchdog

/* verif/ctw_pulse_src.sv */
// Event source standing in for the line that feeds the counter input pin.
// Assumes the bench calls send_pulse from a clocked step; timing is deliberately unrelated to mclk.
`timescale 1ns/1ps
module ctw_pulse_src (
  // Pin.
  output logic counter_pin
);
  initial counter_pin = 1'b0;

  // A glitchy burst ends at the new level, so it carries one net edge each way.
  task automatic send_pulse(input bit glitch);
    if (glitch) begin
      counter_pin = 1'b1;
      #3;
      counter_pin = 1'b0;
      #3;
    end
    counter_pin = 1'b1;
    #100;
    counter_pin = 1'b0;
    #100;
  endtask
endmodule // ctw_pulse_src

/* verif/tb_top.sv */
// Self-checking bench for the core timer and watchdog block.
// Assumes the design's default variant; the watchdog timeout itself is too long to reach here.
`timescale 1ns/1ps
module tb_top;
  import ctw_pkg::*;
  typedef struct {int kind; logic [7:0] exp;} ctw_note_t;
  logic mclk, sys_rst, watchdog_enable_config_word_a, ext_option_config_word_a, counter_pin;
  logic watchdog_service_instruction, powerdown_instruction, counter_wr, pending_clr;
  logic [7:0] counter_wr_data, realtime_counter, timer1_control_b;
  logic [7:0] irq_seen = 8'h00;
  logic [7:0] exp_irq = 8'h00;
  logic rollover_irq, counter_map_effective, timeout_flag, powerdown_flag, watchdog_reset, watchdog_wake, asleep;
  logic [2:0] ps;
  ctw_option_t option;
  ctw_note_t notes[$];
  ctw_note_t nt;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int d;
  int seed;

  ctw_core_timer_watchdog ctw_core_timer_watchdog_inst (.mclk(mclk), .sys_rst(sys_rst),
    .watchdog_enable_config_word_a(watchdog_enable_config_word_a), .ext_option_config_word_a(ext_option_config_word_a), .option(option),
    .counter_pin(counter_pin), .watchdog_service_instruction(watchdog_service_instruction),
    .powerdown_instruction(powerdown_instruction), .counter_wr(counter_wr), .counter_wr_data(counter_wr_data),
    .pending_clr(pending_clr), .realtime_counter(realtime_counter), .rollover_irq(rollover_irq),
    .timer1_control_b(timer1_control_b), .counter_map_effective(counter_map_effective),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .watchdog_reset(watchdog_reset),
    .watchdog_wake(watchdog_wake), .asleep(asleep));
  ctw_pulse_src ctw_pulse_src_inst (.counter_pin(counter_pin));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // The ceiling sits far above the few hundred cycles the sequence needs.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask

  // The pulse is counted mid-cycle, away from the edge that launches it.
  always @(negedge mclk) if (rollover_irq === 1'b1) irq_seen <= irq_seen + 8'h01;

  // Notes are judged just after the falling edge, when the outputs have long settled.
  always @(negedge mclk) begin
    #1;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.kind)
        0: cmp_byte(realtime_counter, nt.exp);
        1: cmp_byte(irq_seen, nt.exp);
        2: cmp_bit(timer1_control_b[CTW_T1CB_PEND_BIT], nt.exp[0]);
        3: cmp_bit(timeout_flag, nt.exp[0]);
        4: cmp_bit(powerdown_flag, nt.exp[0]);
        5: cmp_bit(asleep, nt.exp[0]);
        7: cmp_byte(timer1_control_b, nt.exp);
        8: cmp_bit(watchdog_reset, nt.exp[0]);
        9: cmp_bit(watchdog_wake, nt.exp[0]);
        default: cmp_bit(counter_map_effective, nt.exp[0]);
      endcase
    end
  end

  task automatic note(input int kind, input logic [7:0] exp);
    notes.push_back('{kind, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic load(input logic [7:0] v);
    counter_wr = 1'b1;
    counter_wr_data = v;
    step(1);
    counter_wr = 1'b0;
  endtask

  initial begin
    seed = 32'haf4b8115;
    sys_rst = 1'b1;
    watchdog_enable_config_word_a = 1'b1;
    ext_option_config_word_a = 1'b0;
    option = '0;
    option.scaler_assign = 1'b1;
    option.counter_map_select = 1'b1;
    {watchdog_service_instruction, powerdown_instruction, counter_wr, pending_clr} = 4'h0;
    counter_wr_data = 8'h00;
    step(3);
    sys_rst = 1'b0;
    note(3, 8'h01);
    note(4, 8'h01);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ext_option_config_word_a = i[1];
      option.rollover_irq_disable = i[0];
      load(8'hfd);
      note(0, 8'hfd);
      step(6);
      if (i == 0) exp_irq++;
      note(1, exp_irq);
      note(2, 8'h01);
      note(7, 8'(1 << CTW_T1CB_PEND_BIT));
      note(6, 8'(!i[1]));
      note(1, exp_irq);
      pending_clr = 1'b1;
      step(1);
      pending_clr = 1'b0;
      step(1);
      note(2, 8'h00);
    end
    $display("test rollover done");
    option.scaler_assign = 1'b0;
    for (int k = 0; k < 3; k++) begin
      ps = 3'($unsigned($random(seed)) % 4);
      option.scale_select = ps;
      d = 2 << ps;
      watchdog_service_instruction = 1'b1;
      load(8'h00);
      watchdog_service_instruction = 1'b0;
      step(5 * d + d / 2);
      note(0, 8'h05);
    end
    $display("test prescale done");
    option.scaler_assign = 1'b1;
    option.count_src_select = 1'b1;
    for (int e = 0; e < 2; e++) begin
      option.count_edge_select = e[0];
      step(4);
      load(8'h00);
      for (int p = 0; p < 5; p++) ctw_pulse_src_inst.send_pulse(p[0]);
      step(6);
      note(0, 8'h05);
    end
    $display("test pin events done");
    option.count_src_select = 1'b0;
    powerdown_instruction = 1'b1;
    load(8'h40);
    powerdown_instruction = 1'b0;
    note(4, 8'h00);
    note(5, 8'h01);
    watchdog_enable_config_word_a = 1'b0;
    step(10);
    watchdog_enable_config_word_a = 1'b1;
    note(0, 8'h40);
    note(8, 8'h00);
    note(9, 8'h00);
    watchdog_service_instruction = 1'b1;
    step(1);
    watchdog_service_instruction = 1'b0;
    note(3, 8'h01);
    note(4, 8'h01);
    step(1);
    $display("test sleep and service done");
    sys_rst = 1'b1;
    step(3);
    sys_rst = 1'b0;
    note(0, 8'h00);
    note(5, 8'h00);
    note(4, 8'h01);
    step(2);
    $display("test second reset done");
    close_out();
  end
endmodule // tb_top
